// file: rtl/smbus_pkg.sv
// Constants, types and the packet check helper for the SMBus
// RAM/EEPROM access block. Assumes a 125 MHz system clock.
package smbus_pkg;

  localparam logic [4:0]  ADDR_HI5      = 5'h0c;
  localparam logic [7:0]  RAM_TOP       = 8'hdf;
  localparam int          RAM_SIZE      = 224;
  localparam logic [15:0] EE_BASE       = 16'hf800;
  localparam logic [15:0] EE_LOCK       = 16'hfa00;
  localparam logic [15:0] EE_TOP        = 16'hfbff;
  localparam int          EE_SIZE       = 1024;
  localparam int          PAGE_BYTES    = 32;
  localparam logic [7:0]  EE_HI_MIN     = 8'hf8;
  localparam logic [7:0]  EE_HI_MAX     = 8'hfb;
  localparam logic [7:0]  CMD_BLK_WR    = 8'hfc;
  localparam logic [7:0]  CMD_BLK_RD    = 8'hfd;
  localparam logic [7:0]  CMD_ERASE     = 8'hfe;
  localparam logic [7:0]  CFG_ADDR      = 8'h90;
  localparam int          CFG_ERASE_EN  = 2;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  localparam logic [7:0]  BLK_MAX       = 8'h20;
  localparam logic [7:0]  BLK_COUNT     = 8'h20;
  localparam logic [5:0]  RD_PEC_IDX    = 6'h21;
  localparam logic [7:0]  ERASED        = 8'hff;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  BOOT_COPY_END = 8'ha0;

  localparam int CLK_MHZ       = 125;
  localparam int BOOT_TIME_US  = 1000;
  localparam int PROG_TIME_US  = 250;
  localparam int ERASE_TIME_US = 20000;
  localparam int BOOT_CYC      = BOOT_TIME_US * CLK_MHZ;
  localparam int PROG_CYC      = PROG_TIME_US * CLK_MHZ;
  localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
  localparam int TIMER_W       = 22;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_WR   = 3'h3,
    ST_RD   = 3'h2,
    ST_WAIT = 3'h6
  } st_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sel_hi;
    logic sel_lo;
  } pins_t;

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8

endpackage : smbus_pkg

// file: rtl/link_bit_capture.sv
// Serial clock domain front end: samples the data line on each
// rising serial clock edge. Assumes the system side reads bit_o
// only after it has seen tog_o change.
`timescale 1ns/1ps
`default_nettype none

module link_bit_capture (
  input  wire logic link_clk_i,
  input  wire logic rst_i,
  input  wire logic sda_i,
  output logic      bit_o,
  output logic      tog_o
);

  logic bit_ff;
  logic tog_ff;
  logic nxt_bit;
  logic nxt_tog;

  // Bit stays stable for a whole clock period, toggle carries the event
  always_comb begin
    nxt_bit = sda_i;
    nxt_tog = ~tog_ff;
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_ff <= 1'b1;
      tog_ff <= 1'b0;
    end else begin
      bit_ff <= nxt_bit;
      tog_ff <= nxt_tog;
    end
  end

  assign bit_o = bit_ff;
  assign tog_o = tog_ff;

endmodule : link_bit_capture

`default_nettype wire

// file: rtl/smbus_ram_eeprom_access.sv
// SMBus slave giving byte, block and page erase access to user RAM
// and a 1 KB EEPROM. Assumes open-drain pads outside and an SMBus
// master that keeps to the protocol.
//
// Functional notes
// R01 - RAM 0x00-0xDF, EEPROM 0xF800-0xFBFF byte access
// R02 - EEPROM byte programs only from erased state
// R03 - Erase whole 32-byte pages, 32 pages
// R04 - Erase needs control register bit 2 set
// R05 - Send byte with RAM address sets pointer
// R06 - Erase command 0xFE after page address set
// R07 - Erase starts at command byte, lasts 20 ms
// R08 - No acknowledge while erase runs
// R09 - Write byte stores data into RAM
// R10 - Write 0xF8-0xFB plus byte sets EEPROM pointer
// R11 - Erase page from pointer bits 9 to 5
// R12 - Write word programs EEPROM at given address
// R13 - Block write 0xFC, count, up to 32 bytes
// R14 - Master keeps block inside EEPROM, pre-erased
// R15 - Hold clock low while byte programs, 250 us
// R16 - Receive byte returns location at pointer
// R17 - Block read 0xFD returns 0x20 then 32 bytes
// R18 - Master acks all but last byte, then stops
// R19 - Optional check byte on writes and block reads
// R20 - Check byte is CRC-8, polynomial 0x07
// R21 - Master checks byte, retries on mismatch
// R22 - Bus address 01100 plus two select pins
// R23 - Refuse 0xFA00-0xFBFF unless engine halted
// R24 - Restrict access 1 ms after reset, copy
// R25 - Pointer advances after each block byte
// R26 - 0xFC, 0xFD, 0xFE are commands only
`timescale 1ns/1ps
`default_nettype none

module smbus_ram_eeprom_access #(
  parameter int BOOT_CYC  = smbus_pkg::BOOT_CYC,
  parameter int PROG_CYC  = smbus_pkg::PROG_CYC,
  parameter int ERASE_CYC = smbus_pkg::ERASE_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic       bus_addr_select_hi_i,
  input  wire logic       bus_addr_select_lo_i,
  input  wire logic       sequencing_engine_halted_i,
  output logic [7:0]      config_update_control_o,
  output logic            boot_busy_o,
  output logic            prog_busy_o,
  output logic            erase_busy_o
);

  localparam int TW = smbus_pkg::TIMER_W;

  smbus_pkg::pins_t s1_ff, s2_ff, s3_ff, f_ff, prev_ff;
  smbus_pkg::pins_t nxt_f;
  logic             tog_s1_ff, tog_s2_ff, tog_s3_ff, tog_seen_ff;
  logic             link_bit, link_tog;

  smbus_pkg::st_t   st_ff, nxt_st;
  logic [3:0]       bit_ff, nxt_bit;
  logic [7:0]       sh_ff, nxt_sh;
  logic [5:0]       idx_ff, nxt_idx;
  logic [5:0]       rd_idx_ff, nxt_rd_idx;
  logic [5:0]       cnt_ff, nxt_cnt;
  logic [7:0]       cmd_ff, nxt_cmd;
  logic [15:0]      ptr_ff, nxt_ptr;
  logic [7:0]       crc_ff, nxt_crc;
  logic [7:0]       tx_ff, nxt_tx;
  logic             blk_ff, nxt_blk;
  logic             macked_ff, nxt_macked;
  logic             sda_drv_ff, nxt_sda_drv;
  logic             pend_ff, nxt_pend;
  logic [TW-1:0]    boot_ff, nxt_boot;
  logic [TW-1:0]    prog_ff, nxt_prog;
  logic [TW-1:0]    erase_ff, nxt_erase;
  logic [4:0]       epage_ff, nxt_epage;
  logic [7:0]       copy_ff, nxt_copy;

  logic [7:0]       ram_ff [0:smbus_pkg::RAM_SIZE-1];
  logic [7:0]       ee_ff  [0:smbus_pkg::EE_SIZE-1];
  logic             mem_we;
  logic [15:0]      mem_a;
  logic [7:0]       mem_d;

  logic start, stop, scl_fall, bit_ev;
  logic boot_busy, prog_busy, erase_busy;

  link_bit_capture u_link (
    .link_clk_i (scl_i),
    .rst_i      (rst_i),
    .sda_i      (sda_i),
    .bit_o      (link_bit),
    .tog_o      (link_tog)
  );

  function automatic logic in_ee(input logic [15:0] a);
    return (a >= smbus_pkg::EE_BASE) && (a <= smbus_pkg::EE_TOP);
  endfunction : in_ee

  function automatic logic ee_hi(input logic [7:0] b);
    return (b >= smbus_pkg::EE_HI_MIN) && (b <= smbus_pkg::EE_HI_MAX);
  endfunction : ee_hi

  function automatic logic locked(input logic [15:0] a);
    return (a >= smbus_pkg::EE_LOCK) && (a <= smbus_pkg::EE_TOP) &&
           !sequencing_engine_halted_i;
  endfunction : locked

  function automatic logic [7:0] mem_rd(input logic [15:0] a);
    if (a[15:8] == 8'h00 && a[7:0] <= smbus_pkg::RAM_TOP) begin
      return ram_ff[a[7:0]];
    end else if (in_ee(a)) begin
      return ee_ff[a[9:0]];
    end
    return smbus_pkg::ERASED;
  endfunction : mem_rd

  // Pin filter: a change counts once stages two and three agree
  always_comb begin
    nxt_f = smbus_pkg::pins_t'((s3_ff & ~(s2_ff ^ s3_ff)) |
                               (f_ff & (s2_ff ^ s3_ff)));
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff       <= '1;
      s2_ff       <= '1;
      s3_ff       <= '1;
      f_ff        <= '1;
      prev_ff     <= '1;
      tog_s1_ff   <= 1'b0;
      tog_s2_ff   <= 1'b0;
      tog_s3_ff   <= 1'b0;
      tog_seen_ff <= 1'b0;
    end else begin
      s1_ff       <= {scl_i, sda_i, bus_addr_select_hi_i,
                      bus_addr_select_lo_i};
      s2_ff       <= s1_ff;
      s3_ff       <= s2_ff;
      f_ff        <= nxt_f;
      prev_ff     <= f_ff;
      tog_s1_ff   <= link_tog;
      tog_s2_ff   <= tog_s1_ff;
      tog_s3_ff   <= tog_s2_ff;
      tog_seen_ff <= bit_ev ? tog_s3_ff : tog_seen_ff;
    end
  end

  assign start    = prev_ff.scl & f_ff.scl & prev_ff.sda & ~f_ff.sda;
  assign stop     = prev_ff.scl & f_ff.scl & ~prev_ff.sda & f_ff.sda;
  assign scl_fall = prev_ff.scl & ~f_ff.scl;
  assign bit_ev   = (tog_s2_ff == tog_s3_ff) && (tog_s3_ff != tog_seen_ff);

  assign boot_busy  = boot_ff != '0;
  assign prog_busy  = prog_ff != '0;
  assign erase_busy = erase_ff != '0;

  // Protocol engine, timers and memory write controls
  always_comb begin
    logic [7:0] b;
    logic       ack;
    logic       need_prog;
    b           = sh_ff;
    ack         = 1'b1;
    need_prog   = 1'b0;
    nxt_st      = st_ff;
    nxt_bit     = bit_ff;
    nxt_sh      = sh_ff;
    nxt_idx     = idx_ff;
    nxt_rd_idx  = rd_idx_ff;
    nxt_cnt     = cnt_ff;
    nxt_cmd     = cmd_ff;
    nxt_ptr     = ptr_ff;
    nxt_crc     = crc_ff;
    nxt_tx      = tx_ff;
    nxt_blk     = blk_ff;
    nxt_macked  = macked_ff;
    nxt_sda_drv = sda_drv_ff;
    nxt_pend    = pend_ff;
    nxt_epage   = epage_ff;
    nxt_boot    = boot_busy ? boot_ff - 1'b1 : boot_ff;
    nxt_prog    = prog_busy ? prog_ff - 1'b1 : prog_ff;
    nxt_erase   = erase_busy ? erase_ff - 1'b1 : erase_ff;
    nxt_copy    = (boot_busy && copy_ff < smbus_pkg::BOOT_COPY_END) ?
                  copy_ff + 8'h01 : copy_ff;
    mem_we      = 1'b0;
    mem_a       = ptr_ff;
    mem_d       = sh_ff;
    if (st_ff == smbus_pkg::ST_WR) begin
      need_prog = (ee_hi(cmd_ff) && idx_ff == 6'h02) ||
                  (cmd_ff == smbus_pkg::CMD_BLK_WR && idx_ff >= 6'h02 &&
                   idx_ff <= cnt_ff + 6'h01 && in_ee(ptr_ff) &&
                   !locked(ptr_ff));
    end
    if (start) begin
      nxt_st      = smbus_pkg::ST_ADDR;
      nxt_bit     = 4'h0;
      nxt_sda_drv = 1'b0;
      nxt_pend    = 1'b0;
      if (st_ff == smbus_pkg::ST_IDLE || st_ff == smbus_pkg::ST_WAIT) begin
        nxt_crc = 8'h00;
      end
    end else if (stop) begin
      nxt_st      = smbus_pkg::ST_IDLE;
      nxt_blk     = 1'b0;
      nxt_sda_drv = 1'b0;
      nxt_pend    = 1'b0;
    end else if (st_ff != smbus_pkg::ST_IDLE) begin
      if (bit_ev) begin
        if (bit_ff < 4'h8) begin
          nxt_sh = {sh_ff[6:0], link_bit};
        end
        nxt_macked = ~link_bit;
        if (bit_ff != 4'h9) begin
          nxt_bit = bit_ff + 4'h1;
        end
      end
      if ((scl_fall && bit_ff == 4'h8) || pend_ff) begin
        if (need_prog && prog_busy) begin
          nxt_pend = 1'b1; // R15
        end else begin
          nxt_pend = 1'b0;
          case (st_ff)
            smbus_pkg::ST_ADDR: begin
              nxt_crc = smbus_pkg::crc8(crc_ff, b);
              if (b[7:1] != {smbus_pkg::ADDR_HI5, f_ff.sel_hi,
                             f_ff.sel_lo}) begin // R22
                ack = 1'b0;
              end else if (boot_busy || erase_busy) begin // R08 R24
                ack = 1'b0;
              end else if (b[0]) begin
                if (locked(ptr_ff)) begin // R23
                  ack = 1'b0;
                end else begin
                  nxt_st     = smbus_pkg::ST_RD;
                  nxt_rd_idx = 6'h00;
                end
              end else begin
                nxt_st  = smbus_pkg::ST_WR;
                nxt_idx = 6'h00;
              end
            end
            smbus_pkg::ST_WR: begin
              nxt_crc = smbus_pkg::crc8(crc_ff, b); // R20
              if (idx_ff != 6'h3f) begin
                nxt_idx = idx_ff + 6'h01;
              end
              if (idx_ff == 6'h00) begin
                nxt_cmd = b;
                nxt_blk = 1'b0;
                if (b == smbus_pkg::CMD_ERASE) begin // R26
                  if (ram_ff[smbus_pkg::CFG_ADDR][smbus_pkg::CFG_ERASE_EN]
                      && in_ee(ptr_ff) && !locked(ptr_ff)) begin // R04 R06
                    nxt_erase = TW'(ERASE_CYC); // R07
                    nxt_epage = ptr_ff[9:5]; // R03 R11
                  end
                end else if (b == smbus_pkg::CMD_BLK_RD) begin
                  nxt_blk = 1'b1; // R17
                end else if (b == smbus_pkg::CMD_BLK_WR) begin
                  nxt_blk = 1'b0; // R13
                end else if (b <= smbus_pkg::RAM_TOP) begin
                  nxt_ptr = {8'h00, b}; // R05
                end else if (!ee_hi(b)) begin
                  ack = 1'b0;
                end
              end else if (cmd_ff <= smbus_pkg::RAM_TOP) begin
                if (idx_ff == 6'h01) begin
                  mem_we = 1'b1; // R09
                  mem_a  = {8'h00, cmd_ff};
                end else begin
                  ack = (idx_ff == 6'h02) && (b == crc_ff); // R19
                end
              end else if (ee_hi(cmd_ff)) begin
                if (idx_ff == 6'h01) begin
                  nxt_ptr = {cmd_ff, b}; // R10
                  ack     = !locked({cmd_ff, b}); // R23
                end else if (idx_ff == 6'h02) begin
                  mem_we = 1'b1; // R12
                end else begin
                  ack = (idx_ff == 6'h03) && (b == crc_ff); // R19
                end
              end else if (cmd_ff == smbus_pkg::CMD_BLK_WR) begin
                if (idx_ff == 6'h01) begin
                  nxt_cnt = b[5:0];
                  ack = (b != 8'h00) && (b <= smbus_pkg::BLK_MAX); // R13
                end else if (idx_ff <= cnt_ff + 6'h01) begin
                  mem_we  = !locked(ptr_ff);
                  ack     = !locked(ptr_ff); // R23
                  nxt_ptr = ptr_ff + 16'h0001; // R25
                end else begin
                  ack = (idx_ff == cnt_ff + 6'h02) && (b == crc_ff);
                end
              end else begin
                ack = 1'b0;
              end
            end
            default: begin
              ack = 1'b0;
            end
          endcase
          // Read side releases the line for the master's acknowledge
          nxt_sda_drv = (st_ff == smbus_pkg::ST_RD) ? 1'b0 : ack;
          if (!ack && st_ff != smbus_pkg::ST_RD) begin
            nxt_st = smbus_pkg::ST_WAIT;
          end
        end
      end else if (scl_fall && bit_ff == 4'h9) begin
        nxt_bit     = 4'h0;
        nxt_sda_drv = 1'b0;
        if (st_ff == smbus_pkg::ST_RD) begin
          if (macked_ff) begin // R18 R21
            if (!blk_ff) begin
              nxt_tx = (rd_idx_ff == 6'h00) ? mem_rd(ptr_ff) : // R16
                       smbus_pkg::ERASED;
            end else if (rd_idx_ff == 6'h00) begin
              nxt_tx = smbus_pkg::BLK_COUNT; // R17
            end else if (rd_idx_ff < smbus_pkg::RD_PEC_IDX) begin
              nxt_tx  = mem_rd(ptr_ff); // R01
              nxt_ptr = ptr_ff + 16'h0001; // R25
            end else if (rd_idx_ff == smbus_pkg::RD_PEC_IDX) begin
              nxt_tx = crc_ff; // R19
            end else begin
              nxt_tx = smbus_pkg::ERASED;
            end
            nxt_crc     = smbus_pkg::crc8(crc_ff, nxt_tx); // R20
            nxt_sda_drv = ~nxt_tx[7];
            if (rd_idx_ff != 6'h3f) begin
              nxt_rd_idx = rd_idx_ff + 6'h01;
            end
          end else begin
            nxt_st = smbus_pkg::ST_WAIT;
          end
        end
      end else if (scl_fall && st_ff == smbus_pkg::ST_RD &&
                   bit_ff < 4'h8) begin
        nxt_sda_drv = ~tx_ff[3'h7 - bit_ff[2:0]];
      end
    end
    if (mem_we && in_ee(mem_a)) begin
      nxt_prog = TW'(PROG_CYC); // R15
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff      <= smbus_pkg::ST_IDLE;
      bit_ff     <= 4'h0;
      sh_ff      <= 8'h00;
      idx_ff     <= 6'h00;
      rd_idx_ff  <= 6'h00;
      cnt_ff     <= 6'h00;
      cmd_ff     <= 8'h00;
      ptr_ff     <= 16'h0000;
      crc_ff     <= 8'h00;
      tx_ff      <= 8'h00;
      blk_ff     <= 1'b0;
      macked_ff  <= 1'b0;
      sda_drv_ff <= 1'b0;
      pend_ff    <= 1'b0;
      boot_ff    <= TW'(BOOT_CYC); // R24
      prog_ff    <= '0;
      erase_ff   <= '0;
      epage_ff   <= 5'h00;
      copy_ff    <= 8'h00;
    end else begin
      st_ff      <= nxt_st;
      bit_ff     <= nxt_bit;
      sh_ff      <= nxt_sh;
      idx_ff     <= nxt_idx;
      rd_idx_ff  <= nxt_rd_idx;
      cnt_ff     <= nxt_cnt;
      cmd_ff     <= nxt_cmd;
      ptr_ff     <= nxt_ptr;
      crc_ff     <= nxt_crc;
      tx_ff      <= nxt_tx;
      blk_ff     <= nxt_blk;
      macked_ff  <= nxt_macked;
      sda_drv_ff <= nxt_sda_drv;
      pend_ff    <= nxt_pend;
      boot_ff    <= nxt_boot;
      prog_ff    <= nxt_prog;
      erase_ff   <= nxt_erase;
      epage_ff   <= nxt_epage;
      copy_ff    <= nxt_copy;
    end
  end

  // Storage; programming can only clear bits, so a byte must be erased
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < smbus_pkg::RAM_SIZE; i++) begin
        ram_ff[i] <= smbus_pkg::CFG_RESET;
      end
      for (int i = 0; i < smbus_pkg::EE_SIZE; i++) begin
        ee_ff[i] <= smbus_pkg::ERASED;
      end
    end else begin
      if (boot_busy && copy_ff < smbus_pkg::BOOT_COPY_END) begin
        ram_ff[copy_ff] <= ee_ff[{2'h0, copy_ff}]; // R24
      end
      if (mem_we && mem_a[15:8] == 8'h00) begin
        ram_ff[mem_a[7:0]] <= mem_d; // R01
      end else if (mem_we && in_ee(mem_a)) begin
        ee_ff[mem_a[9:0]] <= ee_ff[mem_a[9:0]] & mem_d; // R02
      end
      if (erase_ff == TW'(1)) begin
        for (int i = 0; i < smbus_pkg::PAGE_BYTES; i++) begin
          ee_ff[{epage_ff, 5'(i)}] <= smbus_pkg::ERASED; // R03
        end
      end
    end
  end

  assign sda_o                   = 1'b0;
  assign sda_oe_n_o              = ~sda_drv_ff;
  assign scl_o                   = 1'b0;
  assign scl_oe_n_o              = ~pend_ff; // R15
  assign config_update_control_o = ram_ff[smbus_pkg::CFG_ADDR];
  assign boot_busy_o             = boot_busy;
  assign prog_busy_o             = prog_busy;
  assign erase_busy_o            = erase_busy;

endmodule : smbus_ram_eeprom_access

`default_nettype wire

// file: verification/smbus_access_props.sv
// Checker on the SMBus RAM/EEPROM block ports, bound below.
// Assumes busy windows sized by the instance parameters.
`timescale 1ns/1ps
`default_nettype none

module smbus_access_props #(
  parameter int BOOT_CYC  = 200,
  parameter int PROG_CYC  = 100,
  parameter int ERASE_CYC = 300
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  input wire logic       scl_i,
  input wire logic       scl_o,
  input wire logic       scl_oe_n_o,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_n_o,
  input wire logic       bus_addr_select_hi_i,
  input wire logic       bus_addr_select_lo_i,
  input wire logic       sequencing_engine_halted_i,
  input wire logic [7:0] config_update_control_o,
  input wire logic       boot_busy_o,
  input wire logic       prog_busy_o,
  input wire logic       erase_busy_o
);
  // 22 bits hold the full erase time
  logic [21:0] boot_ff, prog_ff, ers_ff;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      boot_ff <= 22'h0;
      prog_ff <= 22'h0;
      ers_ff  <= 22'h0;
    end else begin
      boot_ff <= boot_busy_o ? boot_ff + 22'h1 : 22'h0;
      prog_ff <= prog_busy_o ? prog_ff + 22'h1 : 22'h0;
      ers_ff  <= erase_busy_o ? ers_ff + 22'h1 : 22'h0;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_prog_end;
    $fell(prog_busy_o);
  endsequence
  sequence s_ack_start;
    $fell(sda_oe_n_o);
  endsequence

  a_boot_quiet: assert property (boot_busy_o |-> sda_oe_n_o)
    else $error("bus driven in boot window");
  a_boot_only: assert property (boot_busy_o |->
    !prog_busy_o && !erase_busy_o)
    else $error("memory busy during boot");
  a_boot_len: assert property ($fell(boot_busy_o) |->
    boot_ff >= BOOT_CYC - 2 && boot_ff <= BOOT_CYC + 2)
    else $error("boot window length wrong");
  a_boot_copy: assert property ($fell(boot_busy_o) |->
    config_update_control_o == 8'hff)
    else $error("control byte not copied");
  a_prog_len: assert property ($fell(prog_busy_o) |->
    prog_ff >= PROG_CYC - 2 && prog_ff <= PROG_CYC + 2)
    else $error("program time wrong");
  a_erase_len: assert property ($fell(erase_busy_o) |->
    ers_ff >= ERASE_CYC - 2 && ers_ff <= ERASE_CYC + 2)
    else $error("erase time wrong");
  a_stretch_why: assert property (!scl_oe_n_o |->
    prog_busy_o || $past(prog_busy_o))
    else $error("clock held without programming");
  a_stretch_free: assert property (s_prog_end |-> ##[0:2] scl_oe_n_o)
    else $error("clock held after programming");
  a_erase_gate: assert property ($rose(erase_busy_o) |->
    config_update_control_o[2])
    else $error("erase with enable clear");
  a_erase_mute: assert property (s_ack_start |-> ers_ff < 22'd40)
    else $error("answer during erase");
endmodule : smbus_access_props

bind smbus_ram_eeprom_access smbus_access_props #(
  .BOOT_CYC(BOOT_CYC), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)
) u_smbus_access_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .bus_addr_select_hi_i(bus_addr_select_hi_i),
  .bus_addr_select_lo_i(bus_addr_select_lo_i),
  .sequencing_engine_halted_i(sequencing_engine_halted_i),
  .config_update_control_o(config_update_control_o),
  .boot_busy_o(boot_busy_o), .prog_busy_o(prog_busy_o),
  .erase_busy_o(erase_busy_o)
);
`default_nettype wire

// file: verification/smbus_master_model.sv
// SMBus master model: open-drain SCL/SDA, 125 ns bit, own CRC-8.
// Assumes wired-AND lines with pull-ups outside.
`timescale 1ns/1ps
`default_nettype none

module smbus_master_model (
  output logic      scl_m_o,
  output logic      sda_m_o,
  input  wire logic scl_i,
  input  wire logic sda_i
);
  logic [7:0] crc = 8'h00;

  initial begin
    scl_m_o = 1'b1;
    sda_m_o = 1'b1;
  end

  function automatic logic [7:0] crc_add(input logic [7:0] c,
                                         input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    repeat (8) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction : crc_add

  // Long low phase: slave answers several cycles after the fall
  task automatic rise();
    int n = 0;
    scl_m_o = 1'b1;
    while (scl_i !== 1'b1 && n < 20000) begin
      #1;
      n++;
    end
  endtask : rise

  // SDA moves 10 ns after the fall, never with it
  task automatic bit_io(input logic b, output logic r);
    #10 sda_m_o = b;
    #75 rise();
    #20 r = sda_i;
    #20 scl_m_o = 1'b0;
  endtask : bit_io

  task automatic start(input logic fresh);
    if (fresh) crc = 8'h00;
    #10 sda_m_o = 1'b1;
    #40 rise();
    #60 sda_m_o = 1'b0;
    #60 scl_m_o = 1'b0;
  endtask : start

  task automatic stop();
    #10 sda_m_o = 1'b0;
    #40 rise();
    #60 sda_m_o = 1'b1;
    #60;
  endtask : stop

  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    crc = crc_add(crc, d);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr

  // Caller acks all but the last byte
  task automatic rd(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
    crc = crc_add(crc, d);
  endtask : rd
endmodule : smbus_master_model
`default_nettype wire

// file: verification/smbus_ram_eeprom_access_test.sv
// Self-checking bench for the SMBus RAM/EEPROM block.
// Assumes the master model owns SCL; device address 0x32.
`timescale 1ns/1ps
`default_nettype none

module smbus_ram_eeprom_access_test;
  logic       clk;
  logic       rst;
  logic       scl_m;
  logic       sda_m;
  logic       scl_oe_n;
  logic       sda_oe_n;
  logic [1:0] sel;
  logic       halted;
  logic [7:0] cfg;
  logic       boot_busy;
  logic       prog_busy;
  logic       erase_busy;
  logic       seen_st = 1'b0;
  int         mismatches = 0;
  int         n_checks = 0;
  logic       scl_do, sda_do;
  wire logic  scl_w = scl_m & (scl_oe_n | scl_do);
  wire logic  sda_w = sda_m & (sda_oe_n | sda_do);

  smbus_ram_eeprom_access #(
    .BOOT_CYC(200), .PROG_CYC(400), .ERASE_CYC(1000)
  ) u_smbus_ram_eeprom_access (
    .sys_clk_i(clk), .rst_i(rst), .scl_i(scl_w), .scl_o(scl_do),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_do),
    .sda_oe_n_o(sda_oe_n), .bus_addr_select_hi_i(sel[1]),
    .bus_addr_select_lo_i(sel[0]), .sequencing_engine_halted_i(halted),
    .config_update_control_o(cfg), .boot_busy_o(boot_busy),
    .prog_busy_o(prog_busy), .erase_busy_o(erase_busy)
  );
  smbus_master_model u_host (
    .scl_m_o(scl_m), .sda_m_o(sda_m), .scl_i(scl_w), .sda_i(sda_w)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) if (scl_oe_n === 1'b0) seen_st <= 1'b1;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Low n bytes of d, byte n-1 (the address) first; byte nk in send order (0 is the address) expects a nack
  task automatic tx(input logic [47:0] d, input int n, input int nk,
                    input logic pec);
    logic a;
    u_host.start(1'b1);
    for (int i = 0; i < n; i++) begin
      u_host.wr(d[8*(n-1-i) +: 8], a);
      chk({7'h0, a}, (i != nk) ? 8'h01 : 8'h00);
      if (i == nk) break;
    end
    if (pec) u_host.wr(u_host.crc, a);
    if (pec) chk({7'h0, a}, 8'h01);
    u_host.stop();
  endtask : tx

  task automatic rx(input logic [7:0] e);
    logic       a;
    logic [7:0] d;
    u_host.start(1'b1);
    u_host.wr(8'h65, a);
    u_host.rd(1'b0, d);
    u_host.stop();
    chk(d, e);
  endtask : rx

  task automatic blk_rd(input logic [23:0] f);
    logic       a;
    logic [7:0] d;
    logic [7:0] e;
    u_host.start(1'b1);
    u_host.wr(8'h64, a);
    u_host.wr(8'hfd, a);
    u_host.start(1'b0);
    u_host.wr(8'h65, a);
    for (int i = 0; i < 34; i++) begin
      e = i == 0 ? 8'h20 : i < 4 ? f[8*(3-i) +: 8] : 8'hff;
      if (i == 33) e = u_host.crc;
      u_host.rd(i < 33, d);
      chk(d, e);
    end
    u_host.stop();
  endtask : blk_rd

  task automatic wait_idle();
    int n = 0;
    while ((boot_busy | prog_busy | erase_busy) !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) mismatches++;
  endtask : wait_idle

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    sel = 2'b10;
    halted = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tx(48'h64, 1, 0, 1'b0);
    wait_idle();
    chk(cfg, 8'hff);
    tx(48'h66, 1, 0, 1'b0);
    @(posedge clk) sel <= 2'b11;
    tx(48'h66_10, 2, 9, 1'b0);
    tx(48'h64, 1, 0, 1'b0);
    @(posedge clk) sel <= 2'b10;
    tx(48'h64_10_5a, 3, 9, 1'b0);
    tx(48'h64_10, 2, 9, 1'b0);
    rx(8'h5a);
    tx(48'h64_df_c3, 3, 9, 1'b1);
    tx(48'h64_df, 2, 9, 1'b0);
    rx(8'hc3);
    tx(48'h64_e0_00, 3, 1, 1'b0);
    tx(48'h64_90_00, 3, 9, 1'b0);
    chk(cfg, 8'h00);
    tx(48'h64_f8_20_ab, 4, 9, 1'b0);
    tx(48'h64_f8_20_0f, 4, 9, 1'b0);
    wait_idle();
    tx(48'h64_f8_20, 3, 9, 1'b0);
    rx(8'h0b);
    tx(48'h64_f8_1f_00, 4, 9, 1'b0);
    wait_idle();
    tx(48'h64_f8_3f, 3, 9, 1'b0);
    tx(48'h64_fe, 2, 9, 1'b0);
    wait_idle();
    tx(48'h64_f8_20, 3, 9, 1'b0);
    rx(8'h0b);
    tx(48'h64_90_04, 3, 9, 1'b0);
    tx(48'h64_f8_3f, 3, 9, 1'b0);
    tx(48'h64_fe, 2, 9, 1'b0);
    chk({7'h0, erase_busy}, 8'h01);
    tx(48'h64, 1, 0, 1'b0);
    wait_idle();
    tx(48'h64_f8_20, 3, 9, 1'b0);
    rx(8'hff);
    tx(48'h64_f8_1f, 3, 9, 1'b0);
    rx(8'h00);
    tx(48'h64_fa_00, 3, 2, 1'b0);
    @(posedge clk) halted <= 1'b1;
    tx(48'h64_fa_00, 3, 9, 1'b0);
    tx(48'h64_fc_00, 3, 2, 1'b0);
    tx(48'h64_f8_e0, 3, 9, 1'b0);
    tx(48'h64_fc_03_11_22_33, 6, 9, 1'b1);
    wait_idle();
    chk({7'h0, seen_st}, 8'h01);
    tx(48'h64_f8_e0, 3, 9, 1'b0);
    blk_rd(24'h112233);
    finish_test();
  end
endmodule : smbus_ram_eeprom_access_test
`default_nettype wire
